// ===== pkg/cise_regs.vh
// Functional notes
// - Software trap pushes next address, then loads vector 0x001; three cycles.
// - OR immediate into accumulator, updates zero flag, one cycle.
// - OR file register with accumulator; destination bit picks accumulator or register.
// - Auxiliary-page write copies accumulator into register 5..15; flags untouched.
// - Auxiliary-page read copies register 5..15 into accumulator; flags untouched.
// - Long jump loads 11-bit target into program counter; two cycles.
`ifndef CISE_REGS_VH
`define CISE_REGS_VH

`define CISE_OP_NOP          3'h0
`define CISE_OP_TRAP         3'h1
`define CISE_OP_OR_IMM       3'h2
`define CISE_OP_OR_REG       3'h3
`define CISE_OP_AUX_WRITE    3'h4
`define CISE_OP_AUX_READ     3'h5
`define CISE_OP_LONG_JUMP    3'h6

`define CISE_CYC_TRAP        2'h3
`define CISE_CYC_LONG_JUMP   2'h2
`define CISE_CYC_SINGLE      2'h1
`define CISE_CNT_PUSH        2'h2
`define CISE_CNT_LAST        2'h1

`define CISE_TRAP_VECTOR     11'h001
`define CISE_AUX_LOW         4'h5
`define CISE_AUX_HIGH        4'hF

`define CISE_DEST_ACC        1'h0
`define CISE_ACC_RESET       8'h00
`define CISE_ZERO_RESET      1'h0
`define CISE_PC_RESET        11'h000

`endif

// ===== design/cise_aux_mem.v
`timescale 1ns/1ps
module cise_aux_mem #(
  parameter DW = 8,
  parameter AW = 4
) (
  // Clock and reset
  input  wire          ref_clk_in,
  input  wire          rst_in,
  // Write port
  input  wire          we_in,
  input  wire [AW-1:0] waddr_in,
  input  wire [DW-1:0] wdata_in,
  // Read port
  input  wire [AW-1:0] raddr_in,
  output reg  [DW-1:0] rdata_out
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // The array itself has no reset so that it maps onto plain storage.
  always @(posedge ref_clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= {DW{1'b0}};
    end else begin
      rdata_out <= mem[raddr_in];
    end
  end

endmodule

// ===== design/cise_exec.v
`timescale 1ns/1ps
`include "cise_regs.vh"
module cise_exec #(
  parameter PCW = 11,
  parameter DW  = 8,
  parameter FAW = 7
) (
  // Clock and reset
  input  wire           ref_clk_in,
  input  wire           rst_in,
  // Instruction issue
  input  wire           start_in,
  input  wire [2:0]     op_in,
  input  wire [PCW-1:0] operand_in,
  input  wire           dest_in,
  input  wire [PCW-1:0] pc_in,
  input  wire [DW-1:0]  file_data_in,
  // Status
  output reg            busy_out,
  output reg            done_out,
  // Stack and program counter
  output reg            push_out,
  output reg  [PCW-1:0] push_addr_out,
  output reg            pc_load_out,
  output reg  [PCW-1:0] pc_out,
  // Accumulator and flag
  output reg  [DW-1:0]  acc_out,
  output reg            zero_out,
  // File register write-back
  output reg            file_we_out,
  output reg  [FAW-1:0] file_addr_out,
  output reg  [DW-1:0]  file_data_out
);

  localparam S_IDLE = 3'b001;
  localparam S_WAIT = 3'b010;
  localparam S_EXEC = 3'b100;

  reg [2:0]     state;
  reg [2:0]     cur_op;
  reg [PCW-1:0] cur_operand;
  reg           cur_dest;
  reg [PCW-1:0] cur_pc;
  reg [DW-1:0]  cur_file;
  reg [1:0]     cnt;
  reg [2:0]     next_state;
  reg [1:0]     next_cnt;

  wire [DW-1:0] aux_rdata;
  wire          aux_in_range;
  wire [DW-1:0] or_result;
  wire [DW-1:0] or_operand;
  wire          aux_we;

  // Counts include the issue cycle, so a single-cycle op commits on the next edge.
  function [1:0] cise_cycles;
    input [2:0] op;
    begin
      case (op)
        `CISE_OP_TRAP:      cise_cycles = `CISE_CYC_TRAP;
        `CISE_OP_LONG_JUMP: cise_cycles = `CISE_CYC_LONG_JUMP;
        default:            cise_cycles = `CISE_CYC_SINGLE;
      endcase
    end
  endfunction

  function cise_is_zero;
    input [DW-1:0] value;
    begin
      cise_is_zero = (value == {DW{1'b0}});
    end
  endfunction

  function cise_aux_ok;
    input [3:0] sel;
    begin
      cise_aux_ok = (sel >= `CISE_AUX_LOW) && (sel <= `CISE_AUX_HIGH);
    end
  endfunction

  // Selectors below 5 are not auxiliary registers, so such accesses do nothing.
  assign aux_in_range = cise_aux_ok(cur_operand[3:0]);
  assign or_operand   = (cur_op == `CISE_OP_OR_IMM) ? cur_operand[DW-1:0] : cur_file;
  assign or_result    = acc_out | or_operand;
  assign aux_we       = (state == S_EXEC) && (cur_op == `CISE_OP_AUX_WRITE) &&
                        aux_in_range;

  // The counter holds the cycles still to wait once an instruction has been taken.
  always @* begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      S_IDLE: begin
        if (start_in) begin
          next_cnt = cise_cycles(op_in) - 2'h1;
          if (cise_cycles(op_in) == `CISE_CYC_SINGLE) begin
            next_state = S_EXEC;
          end else begin
            next_state = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        // Multi-cycle ops leave the wait state one edge before their commit edge.
        if (cnt == `CISE_CNT_LAST) begin
          next_state = S_EXEC;
        end else begin
          next_cnt = cnt - 2'h1;
        end
      end
      S_EXEC: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // The read address follows the issue port so the read data are ready at commit.
  cise_aux_mem #(
    .DW (DW),
    .AW (4)
  ) u_aux_mem (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .we_in      (aux_we),
    .waddr_in   (cur_operand[3:0]),
    .wdata_in   (acc_out),
    .raddr_in   (operand_in[3:0]),
    .rdata_out  (aux_rdata)
  );

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state         <= S_IDLE;
      cur_op        <= `CISE_OP_NOP;
      cur_operand   <= {PCW{1'b0}};
      cur_dest      <= `CISE_DEST_ACC;
      cur_pc        <= `CISE_PC_RESET;
      cur_file      <= {DW{1'b0}};
      cnt           <= 2'h0;
      busy_out      <= 1'b0;
      done_out      <= 1'b0;
      push_out      <= 1'b0;
      push_addr_out <= `CISE_PC_RESET;
      pc_load_out   <= 1'b0;
      pc_out        <= `CISE_PC_RESET;
      acc_out       <= `CISE_ACC_RESET;
      zero_out      <= `CISE_ZERO_RESET;
      file_we_out   <= 1'b0;
      file_addr_out <= {FAW{1'b0}};
      file_data_out <= {DW{1'b0}};
    end else begin
      // Strobes default low so that each one stands for exactly one cycle.
      done_out    <= 1'b0;
      push_out    <= 1'b0;
      pc_load_out <= 1'b0;
      file_we_out <= 1'b0;
      state       <= next_state;
      cnt         <= next_cnt;
      case (state)
        S_IDLE: begin
          if (start_in) begin
            cur_op      <= op_in;
            cur_operand <= operand_in;
            cur_dest    <= dest_in;
            cur_pc      <= pc_in;
            cur_file    <= file_data_in;
            busy_out    <= 1'b1;
          end
        end
        S_WAIT: begin
          // The return address goes onto the stack before the vector is loaded.
          if ((cur_op == `CISE_OP_TRAP) && (cnt == `CISE_CNT_PUSH)) begin
            push_out      <= 1'b1;
            push_addr_out <= cur_pc + {{(PCW-1){1'b0}}, 1'b1};
          end
        end
        S_EXEC: begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          case (cur_op)
            `CISE_OP_TRAP: begin
              pc_load_out <= 1'b1;
              pc_out      <= `CISE_TRAP_VECTOR;
            end
            `CISE_OP_OR_IMM: begin
              acc_out  <= or_result;
              zero_out <= cise_is_zero(or_result);
            end
            `CISE_OP_OR_REG: begin
              zero_out <= cise_is_zero(or_result);
              if (cur_dest == `CISE_DEST_ACC) begin
                acc_out <= or_result;
              end else begin
                file_we_out   <= 1'b1;
                file_addr_out <= cur_operand[FAW-1:0];
                file_data_out <= or_result;
              end
            end
            `CISE_OP_AUX_READ: begin
              if (aux_in_range) begin
                acc_out <= aux_rdata;
              end
            end
            `CISE_OP_LONG_JUMP: begin
              pc_load_out <= 1'b1;
              pc_out      <= cur_operand;
            end
            default: begin
              pc_load_out <= 1'b0;
            end
          endcase
        end
        default: begin
          busy_out <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ===== bench/cise_chk_assertions.sv
`timescale 1ns/1ps
module cise_chk (
  // Clock, reset and issue
  input wire        ref_clk_in,
  input wire        rst_in,
  input wire        start_in,
  input wire [2:0]  op_in,
  input wire [10:0] operand_in,
  input wire        dest_in,
  input wire [10:0] pc_in,
  input wire [7:0]  file_data_in,
  // Results
  input wire        busy_out,
  input wire        done_out,
  input wire        push_out,
  input wire [10:0] push_addr_out,
  input wire        pc_load_out,
  input wire [10:0] pc_out,
  input wire [7:0]  acc_out,
  input wire        zero_out,
  input wire        file_we_out,
  input wire [6:0]  file_addr_out,
  input wire [7:0]  file_data_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire go = start_in & ~busy_out;
  wire [7:0] imm = operand_in[7:0];
  wire [6:0] faddr = operand_in[6:0];
  sequence s_push;
    push_out && push_addr_out == $past(pc_in, 2) + 11'h001;
  endsequence
  sequence s_load;
    pc_load_out && pc_out == 11'h001 && done_out;
  endsequence
  property p_trap;
    go && op_in == 3'h1 |-> ##2 s_push ##2 s_load;
  endproperty
  a_trap: assert property (p_trap) else $error("trap order wrong");
  property p_busy_trap;
    go && op_in == 3'h1 |-> ##1 busy_out[*3] ##1 !busy_out;
  endproperty
  a_busy_trap: assert property (p_busy_trap) else $error("trap length wrong");
  property p_or_imm;
    go && op_in == 3'h2 |-> ##2 done_out && acc_out == ($past(acc_out, 2) | $past(imm, 2));
  endproperty
  a_or_imm: assert property (p_or_imm) else $error("or immediate wrong");
  property p_zero;
    go && op_in == 3'h2 |-> ##2 zero_out == (acc_out == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_or_file;
    go && op_in == 3'h3 && dest_in |-> ##2 file_we_out && acc_out == $past(acc_out, 2)
      && file_data_out == ($past(acc_out, 2) | $past(file_data_in, 2))
      && file_addr_out == $past(faddr, 2) && zero_out == (file_data_out == 8'h00);
  endproperty
  a_or_file: assert property (p_or_file) else $error("or to file wrong");
  property p_or_acc;
    go && op_in == 3'h3 && !dest_in |-> ##2 !file_we_out
      && acc_out == ($past(acc_out, 2) | $past(file_data_in, 2));
  endproperty
  a_or_acc: assert property (p_or_acc) else $error("or to acc wrong");
  property p_aux_wr;
    go && op_in == 3'h4 |-> ##2 done_out && acc_out == $past(acc_out, 2)
      && zero_out == $past(zero_out, 2);
  endproperty
  a_aux_wr: assert property (p_aux_wr) else $error("aux write wrong");
  property p_aux_rd;
    go && op_in == 3'h5 |-> ##2 done_out && zero_out == $past(zero_out, 2);
  endproperty
  a_aux_rd: assert property (p_aux_rd) else $error("aux read wrong");
  property p_jump;
    go && op_in == 3'h6 |-> ##1 (!push_out && !done_out)[*2] ##1
      (pc_load_out && done_out && pc_out == $past(operand_in, 3));
  endproperty
  a_jump: assert property (p_jump) else $error("jump wrong");
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module testbench;
  logic        ref_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        start_in = 1'b0;
  logic [2:0]  op_in = 3'h0;
  logic [10:0] operand_in = 11'h000;
  logic        dest_in = 1'b0;
  logic [10:0] pc_in = 11'h000;
  logic [7:0]  file_data_in = 8'h00;
  wire         busy_out, done_out, push_out, pc_load_out, zero_out, file_we_out;
  wire  [10:0] push_addr_out, pc_out;
  wire  [7:0]  acc_out, file_data_out;
  wire  [6:0]  file_addr_out;
  logic [47:0] q[$];
  logic [47:0] e;
  logic [10:0] m_pc = 11'h000;
  logic [10:0] m_push = 11'h000;
  logic [6:0]  m_fa = 7'h00;
  logic [7:0]  m_fd = 8'h00;
  logic [7:0]  m_acc = 8'h00;
  logic [7:0]  aux[16];
  logic        m_z = 1'b0;
  integer      n_fail = 0, cmp_count = 0, seed = 32'h4d53, i;
  always #10 ref_clk_in = ~ref_clk_in;
  cise_exec dut (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .start_in      (start_in),
    .op_in         (op_in),
    .operand_in    (operand_in),
    .dest_in       (dest_in),
    .pc_in         (pc_in),
    .file_data_in  (file_data_in),
    .busy_out      (busy_out),
    .done_out      (done_out),
    .push_out      (push_out),
    .push_addr_out (push_addr_out),
    .pc_load_out   (pc_load_out),
    .pc_out        (pc_out),
    .acc_out       (acc_out),
    .zero_out      (zero_out),
    .file_we_out   (file_we_out),
    .file_addr_out (file_addr_out),
    .file_data_out (file_data_out)
  );
  // Called just after an edge; returns at the edge where the next issue may be set up.
  task automatic run(input [2:0] op, input [10:0] opd, input d);
    logic [7:0]  r, fd;
    logic [10:0] pc;
    fd = 8'($random(seed));
    pc = 11'($random(seed));
    start_in <= 1'b1;
    op_in <= op;
    operand_in <= opd;
    dest_in <= d;
    file_data_in <= fd;
    pc_in <= pc;
    r = m_acc | ((op == 3'h2) ? opd[7:0] : fd);
    if (op == 3'h2 || op == 3'h3) m_z = (r == 8'h00);
    if (op == 3'h2 || (op == 3'h3 && !d)) m_acc = r;
    if (op == 3'h3 && d) begin
      m_fa = opd[6:0];
      m_fd = r;
    end
    if (op == 3'h4 && opd[3:0] > 4'h4) aux[opd[3:0]] = m_acc;
    if (op == 3'h5 && opd[3:0] > 4'h4) m_acc = aux[opd[3:0]];
    if (op == 3'h1) m_push = pc + 11'h001;
    if (op == 3'h1) m_pc = 11'h001;
    if (op == 3'h6) m_pc = opd;
    q.push_back({m_acc, m_z, (op == 3'h1 || op == 3'h6), m_pc,
                 (op == 3'h3 && d), m_fa, m_fd, m_push});
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    repeat ((op == 3'h1) ? 3 : (op == 3'h6) ? 2 : 1) @(posedge ref_clk_in);
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk_in) if (done_out === 1'b1) begin
    e = q.pop_front();
    `CHK({acc_out, zero_out}, e[47:39])
    `CHK({pc_load_out, pc_out}, e[38:27])
    `CHK({file_we_out, file_addr_out, file_data_out}, e[26:11])
    `CHK(push_addr_out, e[10:0])
  end
  initial begin
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    run(3'h2, 11'h000, 1'b0);
    run(3'h2, 11'h050, 1'b0);
    run(3'h3, 11'h07F, 1'b1);
    run(3'h1, 11'h000, 1'b0);
    run(3'h6, 11'h7FF, 1'b0);
    for (i = 5; i < 16; i++) run(3'h4, 11'(i), 1'b0);
    run(3'h4, 11'h004, 1'b0);
    run(3'h5, 11'h004, 1'b0);
    run(3'h2, 11'h00F, 1'b0);
    run(3'h4, 11'h006, 1'b0);
    run(3'h5, 11'h005, 1'b0);
    run(3'h5, 11'h006, 1'b0);
    run(3'h3, 11'h012, 1'b0);
    $display("directed test done");
    // Random codes include nop and the refused aux selectors 0 to 4.
    for (i = 0; i < 60; i++) run(3'($random(seed)), 11'($random(seed)), 1'($random(seed)));
    $display("random test done");
    repeat (3) @(posedge ref_clk_in);
    `CHK(q.size(), 0)
    stop_test;
  end
  initial begin
    #200000;
    n_fail++;
    stop_test;
  end
endmodule
bind cise_exec cise_chk chk (
  .ref_clk_in    (ref_clk_in),
  .rst_in        (rst_in),
  .start_in      (start_in),
  .op_in         (op_in),
  .operand_in    (operand_in),
  .dest_in       (dest_in),
  .pc_in         (pc_in),
  .file_data_in  (file_data_in),
  .busy_out      (busy_out),
  .done_out      (done_out),
  .push_out      (push_out),
  .push_addr_out (push_addr_out),
  .pc_load_out   (pc_load_out),
  .pc_out        (pc_out),
  .acc_out       (acc_out),
  .zero_out      (zero_out),
  .file_we_out   (file_we_out),
  .file_addr_out (file_addr_out),
  .file_data_out (file_data_out)
);
